// File: include/hcp_pkg.sv
// constants of the host command byte port
package hcp_pkg;

  // ------------------------------------------------------------------
  // host port offsets
  // ------------------------------------------------------------------
  localparam logic [1:0] OFS_CTRL_STATUS = 2'h0;
  localparam logic [1:0] OFS_CMD_REPLY   = 2'h1;
  localparam logic [1:0] OFS_INTR        = 2'h2;

  // ------------------------------------------------------------------
  // control register bits (write)
  // ------------------------------------------------------------------
  localparam int CTL_BUS_RESET_BIT  = 4;
  localparam int CTL_INT_ACK_BIT    = 5;
  localparam int CTL_SOFT_RESET_BIT = 6;
  localparam int CTL_HARD_RESET_BIT = 7;

  // ------------------------------------------------------------------
  // status register bits (read)
  // ------------------------------------------------------------------
  localparam int ST_INVALID_BIT   = 0;
  localparam int ST_RESERVED_BIT  = 1;
  localparam int ST_RESULT_BIT    = 2;
  localparam int ST_BUSY_BIT      = 3;
  localparam int ST_READY_BIT     = 4;
  localparam int ST_INIT_REQ_BIT  = 5;
  localparam int ST_DIAG_FAIL_BIT = 6;
  localparam int ST_DIAG_ACT_BIT  = 7;

  // ------------------------------------------------------------------
  // interrupt register bits (read)
  // ------------------------------------------------------------------
  localparam int INT_CMD_COMPLETE_BIT = 2;
  localparam int INT_VALID_BIT        = 7;

  // ------------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic       DIAG_ACT_RESET = 1'b1;
  localparam int         CLK_MHZ        = 100;
  localparam int         LED_HALF_MS    = 250;
  localparam int         LED_HALF_CYC   = LED_HALF_MS * CLK_MHZ * 1000;
  localparam int         FIFO_DEPTH     = 8;

endpackage

// File: logic/hcp_port.sv
// host command byte port with its command fifo
`timescale 1ns/1ns

// ------------------------------------------------------------------
// ------------------------------------------------------------------

// ------------------------------------------------------------------
// fifo
// ------------------------------------------------------------------
module hcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             ce_in,
  input  wire logic             flush_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  assign in_ready_out  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out  = mem_reg[rd_reg];

  always_comb
  begin
    push     = in_valid_in && in_ready_out;
    pop      = out_valid_out && out_ready_in;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push)
    begin
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop)
    begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop)
    begin
      cnt_next = cnt_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_next = cnt_reg - 1'b1;
    end
    if (flush_in)
    begin
      wr_next  = '0;
      rd_next  = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else if (ce_in)
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage needs no reset; contents are guarded by the count
  always_ff @(posedge clk_in)
  begin
    if (ce_in && push && !flush_in)
    begin
      mem_reg[wr_reg] <= in_data_in;
    end
  end
endmodule

// ------------------------------------------------------------------
// port top
// ------------------------------------------------------------------
module hcp_port #(
  parameter int DEPTH           = hcp_pkg::FIFO_DEPTH,
  parameter int LED_HALF_CYCLES = hcp_pkg::LED_HALF_CYC
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       ce_in,
  // host i/o port
  input  wire logic [1:0] host_addr_in,
  input  wire logic       host_wr_in,
  input  wire logic       host_rd_in,
  input  wire logic [7:0] host_wdata_in,
  output logic      [7:0] host_rdata_out,
  output logic            host_rvalid_out,
  output logic            irq_out,
  // command bytes to the local processor
  output logic            cmd_valid_out,
  input  wire logic       cmd_ready_in,
  output logic      [7:0] cmd_data_out,
  input  wire logic       cmd_byte_done_in,
  input  wire logic       cmd_done_in,
  input  wire logic       cmd_invalid_in,
  input  wire logic       mbox_init_ok_in,
  input  wire logic       proc_ready_in,
  // reply bytes from the local processor
  input  wire logic       reply_valid_in,
  output logic            reply_ready_out,
  input  wire logic [7:0] reply_data_in,
  input  wire logic       reply_last_in,
  // self-test and resets
  input  wire logic       diag_pass_in,
  input  wire logic       diag_fail_in,
  output logic            hard_reset_out,
  output logic            soft_reset_out,
  output logic            bus_reset_out,
  output logic            led_out
);
  logic       wr_ctrl;
  logic       wr_cmd;
  logic       rd_reply;
  logic       fifo_in_ready;
  logic       hard;
  logic [7:0] status_byte;
  logic [7:0] intr_byte;

  logic       inv_reg,      inv_next;
  logic       rrdy_reg,     rrdy_next;
  logic       last_reg,     last_next;
  logic       busy_reg,     busy_next;
  logic       diag_active_flag_reg,     diag_active_flag_next;
  logic       diag_failure_flag_reg,    diag_failure_flag_next;
  logic       ireq_reg,     ireq_next;
  logic       pend_reg,     pend_next;
  logic       command_complete_cause_reg,     command_complete_cause_next;
  logic       ival_reg,     ival_next;
  logic [7:0] reply_reg,    reply_next;
  logic [7:0] rdata_reg,    rdata_next;
  logic       rvalid_reg,   rvalid_next;
  logic       hard_reg,     hard_next;
  logic       soft_reg,     soft_next;
  logic       sbus_reg,     sbus_next;
  logic [31:0] led_cnt_reg, led_cnt_next;
  logic       led_reg,      led_next;

  assign wr_cmd   = host_wr_in && (host_addr_in == hcp_pkg::OFS_CMD_REPLY);
  assign rd_reply = host_rd_in && (host_addr_in == hcp_pkg::OFS_CMD_REPLY);
  assign wr_ctrl  = host_wr_in && (host_addr_in == hcp_pkg::OFS_CTRL_STATUS);
  assign hard     = wr_ctrl && host_wdata_in[hcp_pkg::CTL_HARD_RESET_BIT];

  // a full fifo drops the host byte; busy already warned the host
  hcp_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .ce_in         (ce_in),
    .flush_in      (hard || soft_reg),
    .in_valid_in   (wr_cmd),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (host_wdata_in),
    .out_valid_out (cmd_valid_out),
    .out_ready_in  (cmd_ready_in),
    .out_data_out  (cmd_data_out)
  );

  always_comb
  begin
    status_byte = hcp_pkg::BYTE_ZERO;
    status_byte[hcp_pkg::ST_INVALID_BIT]   = inv_reg;
    status_byte[hcp_pkg::ST_RESERVED_BIT]  = 1'b0;
    status_byte[hcp_pkg::ST_RESULT_BIT]    = rrdy_reg;
    status_byte[hcp_pkg::ST_BUSY_BIT]      = busy_reg;
    status_byte[hcp_pkg::ST_READY_BIT]     = proc_ready_in && !diag_active_flag_reg
                                             && !diag_failure_flag_reg && !busy_reg;
    status_byte[hcp_pkg::ST_INIT_REQ_BIT]  = ireq_reg;
    status_byte[hcp_pkg::ST_DIAG_FAIL_BIT] = diag_failure_flag_reg;
    status_byte[hcp_pkg::ST_DIAG_ACT_BIT]  = diag_active_flag_reg;
    intr_byte = hcp_pkg::BYTE_ZERO;
    intr_byte[hcp_pkg::INT_CMD_COMPLETE_BIT] = command_complete_cause_reg;
    intr_byte[hcp_pkg::INT_VALID_BIT]        = ival_reg;
  end

  always_comb
  begin
    inv_next     = inv_reg;
    rrdy_next    = rrdy_reg;
    last_next    = last_reg;
    busy_next    = busy_reg;
    diag_active_flag_next    = diag_active_flag_reg;
    diag_failure_flag_next   = diag_failure_flag_reg;
    ireq_next    = ireq_reg;
    pend_next    = pend_reg;
    command_complete_cause_next    = command_complete_cause_reg;
    ival_next    = ival_reg;
    reply_next   = reply_reg;
    rdata_next   = rdata_reg;
    rvalid_next  = host_rd_in;
    hard_next    = hard;
    soft_next    = wr_ctrl && host_wdata_in[hcp_pkg::CTL_SOFT_RESET_BIT];
    sbus_next    = wr_ctrl && host_wdata_in[hcp_pkg::CTL_BUS_RESET_BIT];
    led_cnt_next = led_cnt_reg;
    led_next     = led_reg;

    // host read data, registered
    if (host_rd_in)
    begin
      unique case (host_addr_in)
        hcp_pkg::OFS_CTRL_STATUS: rdata_next = status_byte;
        hcp_pkg::OFS_CMD_REPLY:   rdata_next = reply_reg;
        hcp_pkg::OFS_INTR:        rdata_next = intr_byte;
        default:                  rdata_next = hcp_pkg::BYTE_ZERO;
      endcase
    end

    if (wr_ctrl && host_wdata_in[hcp_pkg::CTL_INT_ACK_BIT])
    begin
      command_complete_cause_next = 1'b0;
      ival_next = 1'b0;
      inv_next  = 1'b0;
    end

    if (rd_reply && rrdy_reg)
    begin
      rrdy_next = 1'b0;
      if (last_reg)
      begin
        pend_next = 1'b1;
      end
    end
    if (reply_valid_in && reply_ready_out)
    begin
      reply_next = reply_data_in;
      last_next  = reply_last_in;
      rrdy_next  = 1'b1;
    end

    if (cmd_byte_done_in && !cmd_valid_out)
    begin
      busy_next = 1'b0;
    end
    if (wr_cmd && fifo_in_ready)
    begin
      busy_next = 1'b1;
    end

    if (cmd_done_in)
    begin
      pend_next = 1'b1;
    end
    if (cmd_invalid_in)
    begin
      inv_next = 1'b1;
    end
    // withhold while valid or result ready
    if (pend_reg && !ival_reg && !rrdy_reg)
    begin
      // a completion in this same cycle stays queued, set wins
      pend_next = cmd_done_in;
      command_complete_cause_next = 1'b1;
      ival_next = 1'b1;
    end

    if (mbox_init_ok_in)
    begin
      ireq_next = 1'b0;
    end
    if (diag_pass_in && diag_active_flag_reg)
    begin
      diag_active_flag_next = 1'b0;
      ireq_next = 1'b1;
    end
    if (diag_fail_in && diag_active_flag_reg)
    begin
      diag_failure_flag_next = 1'b1;
    end
    if (soft_reg)
    begin
      ireq_next = !diag_failure_flag_reg;
      command_complete_cause_next = 1'b0;
      ival_next = 1'b0;
      pend_next = 1'b0;
      busy_next = 1'b0;
      rrdy_next = 1'b0;
    end

    if (diag_failure_flag_reg)
    begin
      if (led_cnt_reg >= 32'(LED_HALF_CYCLES - 1))
      begin
        led_cnt_next = '0;
        led_next     = !led_reg;
      end
      else
      begin
        led_cnt_next = led_cnt_reg + 32'h0000_0001;
      end
    end

    if (hard)
    begin
      diag_active_flag_next  = 1'b1;
      diag_failure_flag_next = 1'b0;
      ireq_next  = 1'b0;
      inv_next   = 1'b0;
      rrdy_next  = 1'b0;
      busy_next  = 1'b0;
      pend_next  = 1'b0;
      command_complete_cause_next  = 1'b0;
      ival_next  = 1'b0;
      led_cnt_next = '0;
      led_next   = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      inv_reg     <= 1'b0;
      rrdy_reg    <= 1'b0;
      last_reg    <= 1'b0;
      busy_reg    <= 1'b0;
      diag_active_flag_reg    <= hcp_pkg::DIAG_ACT_RESET;
      diag_failure_flag_reg   <= 1'b0;
      ireq_reg    <= 1'b0;
      pend_reg    <= 1'b0;
      command_complete_cause_reg    <= 1'b0;
      ival_reg    <= 1'b0;
      reply_reg   <= hcp_pkg::BYTE_ZERO;
      rdata_reg   <= hcp_pkg::BYTE_ZERO;
      rvalid_reg  <= 1'b0;
      hard_reg    <= 1'b0;
      soft_reg    <= 1'b0;
      sbus_reg    <= 1'b0;
      led_cnt_reg <= '0;
      led_reg     <= 1'b0;
    end
    else if (ce_in)
    begin
      inv_reg     <= inv_next;
      rrdy_reg    <= rrdy_next;
      last_reg    <= last_next;
      busy_reg    <= busy_next;
      diag_active_flag_reg    <= diag_active_flag_next;
      diag_failure_flag_reg   <= diag_failure_flag_next;
      ireq_reg    <= ireq_next;
      pend_reg    <= pend_next;
      command_complete_cause_reg    <= command_complete_cause_next;
      ival_reg    <= ival_next;
      reply_reg   <= reply_next;
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
      hard_reg    <= hard_next;
      soft_reg    <= soft_next;
      sbus_reg    <= sbus_next;
      led_cnt_reg <= led_cnt_next;
      led_reg     <= led_next;
    end
  end

  // reply slot holds one byte; hold off during self-test
  assign reply_ready_out = !rrdy_reg && !diag_active_flag_reg;
  assign host_rdata_out  = rdata_reg;
  assign host_rvalid_out = rvalid_reg;
  assign irq_out         = ival_reg;
  assign hard_reset_out  = hard_reg;
  assign soft_reset_out  = soft_reg;
  assign bus_reset_out   = sbus_reg;
  assign led_out         = led_reg;
endmodule

// File: sim/hcp_port_sva.sv
// assertion checker for the host command byte port
`timescale 1ns/1ns
module hcp_port_sva (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       ce_in,
  // host port
  input wire logic [1:0] host_addr_in,
  input wire logic       host_wr_in,
  input wire logic       host_rd_in,
  input wire logic [7:0] host_wdata_in,
  input wire logic [7:0] host_rdata_out,
  input wire logic       irq_out,
  // processor side
  input wire logic       cmd_valid_out,
  input wire logic       cmd_done_in,
  input wire logic       reply_valid_in,
  input wire logic       reply_ready_out,
  input wire logic       hard_reset_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic ctl_wr;
  assign ctl_wr = ce_in && host_wr_in && host_addr_in == 2'h0;
  // ----------
  // sequences
  // ----------
  // completion with nothing in the way of posting
  sequence s_done_free;
    ce_in && cmd_done_in && !irq_out && reply_ready_out
      && !reply_valid_in && !ctl_wr && !$past(ctl_wr);
  endsequence
  sequence s_quiet;
    ce_in && !ctl_wr;
  endsequence
  sequence s_ack;
    ctl_wr && host_wdata_in[5];
  endsequence
  // ----------
  // assertions
  // ----------
  chk_rsvd_zero: assert property (
    ce_in && host_rd_in && host_addr_in == 2'h0 |=> !host_rdata_out[1])
    else $error("reserved status bit read as one");
  chk_unmapped_zero: assert property (
    ce_in && host_rd_in && host_addr_in == 2'h3 |=> host_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_cmd_offer: assert property (
    ce_in && host_wr_in && host_addr_in == 2'h1 && !$past(ctl_wr)
      |=> cmd_valid_out)
    else $error("command byte not offered");
  chk_reply_stall: assert property (
    ce_in && reply_valid_in && reply_ready_out |=> !reply_ready_out)
    else $error("reply load left result slot open");
  chk_irq_ack: assert property (
    s_ack |=> !irq_out)
    else $error("acknowledge left interrupt high");
  chk_irq_post: assert property (
    s_done_free ##1 s_quiet |=> irq_out)
    else $error("completion not posted in time");
  chk_irq_hold: assert property (
    irq_out && !ctl_wr && !$past(ctl_wr) |=> irq_out)
    else $error("interrupt dropped without acknowledge");
  chk_hard_pulse: assert property (
    ctl_wr && host_wdata_in[7] |=> hard_reset_out ##1 !hard_reset_out)
    else $error("hard reset pulse wrong");
endmodule

bind hcp_port hcp_port_sva hcp_port_sva_inst (
  .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
  .host_addr_in(host_addr_in), .host_wr_in(host_wr_in),
  .host_rd_in(host_rd_in), .host_wdata_in(host_wdata_in),
  .host_rdata_out(host_rdata_out), .irq_out(irq_out),
  .cmd_valid_out(cmd_valid_out), .cmd_done_in(cmd_done_in),
  .reply_valid_in(reply_valid_in), .reply_ready_out(reply_ready_out),
  .hard_reset_out(hard_reset_out)
);

// File: sim/hcp_proc_model.sv
// local processor model behind the command and reply paths
`timescale 1ns/1ns
module hcp_proc_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       hard_reset_in,
  input  wire logic       stall_in,
  // command bytes
  input  wire logic       cmd_valid_in,
  output logic            cmd_ready_out,
  input  wire logic [7:0] cmd_data_in,
  output logic            byte_done_out,
  output logic            done_out,
  output logic            invalid_out,
  output logic            init_ok_out,
  output logic            idle_out,
  // reply bytes
  output logic            reply_valid_out,
  input  wire logic       reply_ready_in,
  output logic      [7:0] reply_data_out,
  output logic            reply_last_out,
  output int              taken_out
);
  // opcode bits 1:0 parameters, 5:4 replies, 7 invalid
  int         need;
  int         nrep;
  logic [7:0] op;
  logic [7:0] ridx;
  assign idle_out        = need == 0 && nrep == 0;
  assign cmd_ready_out   = !stall_in && nrep == 0;
  assign reply_valid_out = nrep > 0;
  assign reply_last_out  = nrep == 1;
  // idle line shows inverted data so stale bytes cannot pass
  assign reply_data_out  = nrep > 0 ? op + ridx : ~op;
  always @(posedge clk_in or negedge resetn_in)
  begin : seq
    logic [7:0] o;
    int         n;
    {byte_done_out, done_out, invalid_out, init_ok_out} <= 4'h0;
    if (!resetn_in || hard_reset_in)
    begin
      need      <= 0;
      nrep      <= 0;
      taken_out <= 0;
      op        <= 8'h00;
      ridx      <= 8'h00;
    end
    else
    begin
      if (reply_valid_out && reply_ready_in)
      begin
        nrep <= nrep - 1;
        ridx <= ridx + 8'h01;
      end
      if (cmd_valid_in && cmd_ready_out)
      begin
        o = need == 0 ? cmd_data_in : op;
        n = need == 0 ? int'(cmd_data_in[1:0]) : need - 1;
        op            <= o;
        need          <= n;
        taken_out     <= taken_out + 1;
        byte_done_out <= 1'b1;
        if (n == 0)
        begin
          done_out    <= o[7] || o[5:4] == 2'h0;
          invalid_out <= o[7];
          init_ok_out <= o == 8'h01;
          nrep        <= o[7] ? 0 : int'(o[5:4]);
          ridx        <= 8'h00;
        end
      end
    end
  end
endmodule

// File: sim/hcp_port_bench.sv
// self-checking bench for the host command byte port
`timescale 1ns/1ns
module hcp_port_bench;
  logic       clk_in, resetn_in, ce_in, host_wr_in, host_rd_in;
  logic [1:0] host_addr_in;
  logic [7:0] host_wdata_in, host_rdata_out, cmd_data_out, reply_data_in;
  logic       host_rvalid_out, irq_out, cmd_valid_out, cmd_ready_in;
  logic       cmd_byte_done_in, cmd_done_in, cmd_invalid_in;
  logic       mbox_init_ok_in, proc_ready_in, reply_valid_in;
  logic       reply_ready_out, reply_last_in, diag_pass_in, diag_fail_in;
  logic       hard_reset_out, led_out, stall, init_exp, soft_o, bus_o;
  int         taken, err_count, num_checks, cycles;
  logic [7:0] ops [6] = '{8'h01, 8'h02, 8'h05, 8'h13, 8'h22, 8'h81};

  hcp_port #(.LED_HALF_CYCLES(4)) hcp_port_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .host_addr_in(host_addr_in), .host_wr_in(host_wr_in),
    .host_rd_in(host_rd_in), .host_wdata_in(host_wdata_in),
    .host_rdata_out(host_rdata_out), .host_rvalid_out(host_rvalid_out),
    .irq_out(irq_out), .cmd_valid_out(cmd_valid_out),
    .cmd_ready_in(cmd_ready_in), .cmd_data_out(cmd_data_out),
    .cmd_byte_done_in(cmd_byte_done_in), .cmd_done_in(cmd_done_in),
    .cmd_invalid_in(cmd_invalid_in), .mbox_init_ok_in(mbox_init_ok_in),
    .proc_ready_in(proc_ready_in), .reply_valid_in(reply_valid_in),
    .reply_ready_out(reply_ready_out), .reply_data_in(reply_data_in),
    .reply_last_in(reply_last_in), .diag_pass_in(diag_pass_in),
    .diag_fail_in(diag_fail_in), .hard_reset_out(hard_reset_out),
    .soft_reset_out(soft_o), .bus_reset_out(bus_o), .led_out(led_out)
  );
  hcp_proc_model hcp_proc_model_inst (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .hard_reset_in(hard_reset_out), .stall_in(stall),
    .cmd_valid_in(cmd_valid_out), .cmd_ready_out(cmd_ready_in),
    .cmd_data_in(cmd_data_out), .byte_done_out(cmd_byte_done_in),
    .done_out(cmd_done_in), .invalid_out(cmd_invalid_in),
    .init_ok_out(mbox_init_ok_in), .idle_out(proc_ready_in),
    .reply_valid_out(reply_valid_in), .reply_ready_in(reply_ready_out),
    .reply_data_out(reply_data_in), .reply_last_out(reply_last_in),
    .taken_out(taken)
  );

  always #5 clk_in = ~clk_in;
  // ----------
  // helpers
  // ----------
  task automatic close_out;
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // whole run needs a few hundred cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // idle cycle after each access keeps strobes single-assigned
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    host_addr_in  = a;
    host_wdata_in = d;
    host_wr_in    = 1'b1;
    @(negedge clk_in);
    host_wr_in = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    host_addr_in = a;
    host_rd_in   = 1'b1;
    @(negedge clk_in);
    host_rd_in = 1'b0;
    d          = host_rdata_out;
    chk(8'(host_rvalid_out), 8'h01, "read valid");
    @(negedge clk_in);
  endtask
  task automatic poll(input logic [1:0] a, input int b, input logic x);
    logic [7:0] s;
    int         i;
    for (i = 0; i < 60; i++)
    begin
      rd(a, s);
      if (s[b] === x)
        break;
    end
    chk(8'(s[b]), 8'(x), "polled flag");
  endtask
  task automatic diag(input logic pass);
    diag_pass_in = pass;
    diag_fail_in = !pass;
    @(negedge clk_in);
    {diag_pass_in, diag_fail_in} = 2'h0;
  endtask
  task automatic run_cmd(input logic [7:0] op);
    logic [7:0] v;
    int         i;
    int         exp_q[$];
    if (op != 8'h02 && op != 8'h05)
      poll(2'h0, 4, 1'b1);
    poll(2'h0, 3, 1'b0);
    wr(2'h1, op);
    for (i = 0; i < int'(op[1:0]); i++)
    begin
      poll(2'h0, 3, 1'b0);
      wr(2'h1, 8'($urandom));
    end
    for (i = 0; i < int'(op[5:4]) && !op[7]; i++)
      exp_q.push_back(int'(op) + i);
    while (exp_q.size() > 0)
    begin
      poll(2'h0, 2, 1'b1);
      chk(8'(irq_out), 8'h00, "irq withheld");
      rd(2'h1, v);
      chk(v, 8'(exp_q.pop_front()), "reply byte");
    end
    poll(2'h2, 7, 1'b1);
    rd(2'h2, v);
    chk(v, 8'h84, "interrupt reg");
    if (op == 8'h01)
      init_exp = 1'b0;
    rd(2'h0, v);
    chk(v, {2'b00, init_exp, 4'h8, op[7]},
        "status done");
    wr(2'h0, 8'h20);
    rd(2'h2, v);
    chk(v, 8'h00, "interrupt cleared");
  endtask
  // ----------
  // main sequence
  // ----------
  initial
  begin
    logic [7:0] v;
    logic       l0;
    int         i;
    int         t0;
    clk_in = 1'b0;
    ce_in  = 1'b1;
    init_exp = 1'b1;
    host_addr_in  = 2'h0;
    host_wdata_in = 8'h00;
    {resetn_in, host_wr_in, host_rd_in, diag_pass_in, diag_fail_in} = 5'h00;
    stall = 1'b0;
    void'($urandom(32'h0000_fdbf));
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    rd(2'h0, v);
    chk(v, 8'h80, "status at reset");
    rd(2'h3, v);
    chk(v, 8'h00, "unmapped read");
    diag(1'b1);
    rd(2'h0, v);
    chk(v, 8'h30, "status after pass");
    foreach (ops[k]) run_cmd(ops[k]);
    // stalled processor: ninth byte has no room
    t0    = taken;
    stall = 1'b1;
    for (i = 0; i < 9; i++)
      wr(2'h1, i % 4 == 0 ? 8'h03 : 8'($urandom));
    rd(2'h0, v);
    chk(v & 8'h18, 8'h08, "busy, not ready");
    stall = 1'b0;
    poll(2'h0, 3, 1'b0);
    chk(8'(taken - t0), 8'(hcp_pkg::FIFO_DEPTH), "bytes kept");
    wr(2'h0, 8'h80);
    rd(2'h0, v);
    chk(v, 8'h80, "status after hard reset");
    diag(1'b0);
    rd(2'h0, v);
    chk(v & 8'h7f, 8'h40, "status after failure");
    l0 = led_out;
    repeat (4) @(negedge clk_in);
    chk(8'(led_out ^ l0), 8'h01, "indicator toggles");
    // clock enable low freezes the blink counter
    ce_in = 1'b0;
    l0    = led_out;
    repeat (8) @(negedge clk_in);
    chk(8'(led_out ^ l0), 8'h00, "indicator frozen");
    ce_in = 1'b1;
    // soft and bus reset together; failure must survive
    host_addr_in  = 2'h0;
    host_wdata_in = 8'h50;
    host_wr_in    = 1'b1;
    @(negedge clk_in);
    host_wr_in = 1'b0;
    chk({6'h00, soft_o, bus_o}, 8'h03, "reset pulses");
    @(negedge clk_in);
    chk({6'h00, soft_o, bus_o}, 8'h00, "pulses end");
    rd(2'h0, v);
    chk(v & 8'h7f, 8'h40, "failure kept");
    wr(2'h0, 8'h80);
    diag(1'b1);
    rd(2'h0, v);
    chk(v, 8'h30, "status after second pass");
    close_out();
  end
endmodule
